// [rtl/hbd_drive_ctrl.sv]
/*
  H-bridge drive control: input decode, standby and wake, current
  regulation off-time with slow or mixed decay, and fault handling for
  overcurrent with retry, over-temperature and supply undervoltage.
  Assumes the comparators and pin levels arrive asynchronously and that
  gate commands go to drivers that add their own propagation delay.
*/
`timescale 1ns/1ns

module hbd_drive_ctrl #(
  parameter int unsigned IDLE_CYC = hbd_pkg::IDLE_ENTRY_CYC,
  parameter int unsigned RETRY_CYC = hbd_pkg::RETRY_CYC,
  parameter int unsigned WAKE_CYC = hbd_pkg::WAKE_DELAY_CYC,
  parameter int unsigned HOLD_CYC = hbd_pkg::WAKE_HOLD_CYC,
  parameter int unsigned OFF_CYC = hbd_pkg::OFF_TIME_CYC,
  parameter int unsigned UV_CYC = hbd_pkg::UV_DEG_CYC,
  parameter int unsigned OC_CYC = hbd_pkg::OC_DEG_CYC
) (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic rstn,
  // Control inputs from the host, pulled low when undriven
  input wire logic bridge_input_a,
  input wire logic bridge_input_b,
  // Configuration straps
  input wire logic mixed_decay_sel,
  // Analog comparator results
  input wire hbd_pkg::hbd_sense_t sense,
  // Gate commands for the two half-bridges
  output hbd_pkg::hbd_gate_t gate_a,
  output hbd_pkg::hbd_gate_t gate_b,
  // Status
  output logic standby,
  output logic overcurrent_fault,
  output logic thermal_fault,
  output logic supply_low_fault,
  output logic internal_supply_on
);

  // ==========================================================================
  // Input synchronisation
  // ==========================================================================
  localparam int unsigned NSYNC = 7;
  logic [NSYNC-1:0] raw_in;
  logic [NSYNC-1:0] sync_in;
  hbd_pkg::hbd_sense_t sense_s;
  logic in_a;
  logic in_b;
  logic mixed_s;

  // Pulldowns live in the pad; a floating pin arrives here as zero
  assign raw_in = {bridge_input_a, bridge_input_b, mixed_decay_sel, sense};

  hbd_sync #(.WIDTH(NSYNC)) u_sync (
    .clk_sys(clk_sys),
    .rstn(rstn),
    .async_in(raw_in),
    .sync_out(sync_in)
  );

  assign in_a = sync_in[6];
  assign in_b = sync_in[5];
  assign mixed_s = sync_in[4];
  assign sense_s = sync_in[3:0];

  // ==========================================================================
  // Control state
  // ==========================================================================
  typedef enum logic [2:0] {
    ST_STANDBY,
    ST_WAKE,
    ST_RUN,
    ST_OFF_FAST,
    ST_OFF_SLOW,
    ST_OC_WAIT
  } hbd_state_t;

  hbd_state_t state_q;
  hbd_state_t state_d;
  logic [hbd_pkg::CNT_W-1:0] tmr_q;
  logic [hbd_pkg::CNT_W-1:0] tmr_d;
  logic [hbd_pkg::CNT_W-1:0] idle_q;
  logic [hbd_pkg::CNT_W-1:0] idle_d;
  logic [hbd_pkg::CNT_W-1:0] uv_cnt_q;
  logic [hbd_pkg::CNT_W-1:0] oc_cnt_q;
  logic uv_q;
  logic ot_q;
  hbd_pkg::hbd_drive_t trip_dir_q;
  hbd_pkg::hbd_drive_t drive_req;
  hbd_pkg::hbd_drive_t drive_eff;

  wire any_in = in_a | in_b;
  wire tmr_zero = (tmr_q == '0);
  wire idle_done = (idle_q >= hbd_pkg::CNT_W'(IDLE_CYC));
  wire hold_done = (tmr_q >= hbd_pkg::CNT_W'(HOLD_CYC));
  wire fault_stop = uv_q | ot_q;

  // Decode of the two inputs
  assign drive_req = hbd_pkg::hbd_drive_t'({in_a, in_b});

  // ==========================================================================
  // Fault deglitch
  // ==========================================================================
  // Undervoltage latches after a steady low supply, releases at once
  wire uv_hit = uv_cnt_q >= hbd_pkg::CNT_W'(UV_CYC);
  wire oc_hit = oc_cnt_q >= hbd_pkg::CNT_W'(OC_CYC);

  always_ff @(posedge clk_sys) begin
    if (!rstn) begin
      uv_cnt_q <= '0;
      oc_cnt_q <= '0;
      uv_q <= 1'b0;
      ot_q <= 1'b0;
    end else begin
      uv_cnt_q <= sense_s.supply_low ? (uv_hit ? uv_cnt_q : uv_cnt_q + 1'b1) : '0;
      oc_cnt_q <= sense_s.overcurrent ? (oc_hit ? oc_cnt_q : oc_cnt_q + 1'b1) : '0;
      uv_q <= sense_s.supply_low & uv_hit;
      ot_q <= sense_s.thermal_fault;
    end
  end

  // ==========================================================================
  // Sequencer
  // ==========================================================================
  always_comb begin
    state_d = state_q;
    tmr_d = tmr_q;
    idle_d = any_in ? '0 : (idle_done ? idle_q : idle_q + 1'b1);
    unique case (state_q)
      ST_STANDBY: begin
        // Wake needs an input held high for the hold time
        tmr_d = any_in ? (hold_done ? tmr_q : tmr_q + 1'b1) : '0;
        if (hold_done && any_in) begin
          state_d = ST_WAKE;
          tmr_d = hbd_pkg::CNT_W'(WAKE_CYC);
        end
      end
      ST_WAKE: begin
        tmr_d = tmr_q - 1'b1;
        if (tmr_zero) begin
          state_d = ST_RUN;
        end
      end
      ST_RUN: begin
        // Grounded sense never raises the comparator, so no trip occurs
        if (idle_done) begin
          state_d = ST_STANDBY;
          tmr_d = '0;
        end else if (sense_s.regulation_limit && drive_req != hbd_pkg::HBD_COAST) begin
          state_d = mixed_s ? ST_OFF_FAST : ST_OFF_SLOW;
          tmr_d = mixed_s ? hbd_pkg::CNT_W'(OFF_CYC / 2) : hbd_pkg::CNT_W'(OFF_CYC);
        end
      end
      ST_OFF_FAST: begin
        tmr_d = tmr_q - 1'b1;
        if (tmr_zero) begin
          state_d = ST_OFF_SLOW;
          tmr_d = hbd_pkg::CNT_W'(OFF_CYC - OFF_CYC / 2);
        end
      end
      ST_OFF_SLOW: begin
        tmr_d = tmr_q - 1'b1;
        if (tmr_zero) begin
          state_d = ST_RUN;
        end
      end
      ST_OC_WAIT: begin
        tmr_d = tmr_zero ? tmr_q : tmr_q - 1'b1;
        if (tmr_zero && !sense_s.overcurrent) begin
          state_d = ST_RUN;
        end
      end
      default: begin
        state_d = ST_STANDBY;
      end
    endcase
    // Overcurrent wins from any state but standby and wake, and restarts the retry wait
    if (oc_hit && state_q != ST_STANDBY && state_q != ST_WAKE) begin
      state_d = ST_OC_WAIT;
      tmr_d = hbd_pkg::CNT_W'(RETRY_CYC);
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!rstn) begin
      state_q <= ST_STANDBY;
      tmr_q <= '0;
      idle_q <= '0;
      trip_dir_q <= hbd_pkg::HBD_COAST;
    end else begin
      state_q <= state_d;
      tmr_q <= tmr_d;
      idle_q <= idle_d;
      if (state_q == ST_RUN) begin
        trip_dir_q <= drive_req;
      end
    end
  end

  // ==========================================================================
  // Output selection
  // ==========================================================================
  // Reverse the captured drive in the fast half; brake stays brake
  wire [1:0] rev_dir = (trip_dir_q == hbd_pkg::HBD_FORWARD) ? hbd_pkg::HBD_REVERSE :
                       (trip_dir_q == hbd_pkg::HBD_REVERSE) ? hbd_pkg::HBD_FORWARD :
                       trip_dir_q;
  wire run_st = (state_q == ST_RUN);
  wire fast_st = (state_q == ST_OFF_FAST);
  wire slow_st = (state_q == ST_OFF_SLOW);
  wire oc_st = (state_q == ST_OC_WAIT);

  // Faults, standby and wake force coast ahead of everything
  assign drive_eff = fault_stop ? hbd_pkg::HBD_COAST :
                     run_st ? drive_req :
                     fast_st ? hbd_pkg::hbd_drive_t'(rev_dir) :
                     slow_st ? hbd_pkg::HBD_BRAKE :
                     hbd_pkg::HBD_COAST;

  wire drive_on = (drive_eff != hbd_pkg::HBD_COAST);
  wire a_high = (drive_eff == hbd_pkg::HBD_FORWARD);
  wire b_high = (drive_eff == hbd_pkg::HBD_REVERSE);

  hbd_half_bridge u_half_a (
    .clk_sys(clk_sys),
    .rstn(rstn),
    .drive_en(drive_on),
    .drive_high(a_high),
    .gate(gate_a)
  );

  hbd_half_bridge u_half_b (
    .clk_sys(clk_sys),
    .rstn(rstn),
    .drive_en(drive_on),
    .drive_high(b_high),
    .gate(gate_b)
  );

  // ==========================================================================
  // Status outputs
  // ==========================================================================
  // Internal supply is off in standby, in the overcurrent wait and during over-temperature; undervoltage leaves it on
  always_ff @(posedge clk_sys) begin
    if (!rstn) begin
      standby <= 1'b1;
      overcurrent_fault <= 1'b0;
      thermal_fault <= 1'b0;
      supply_low_fault <= 1'b0;
      internal_supply_on <= 1'b0;
    end else begin
      standby <= (state_d == ST_STANDBY);
      overcurrent_fault <= (state_d == ST_OC_WAIT);
      thermal_fault <= ot_q;
      supply_low_fault <= uv_q;
      internal_supply_on <= ~ot_q & ~(state_d == ST_OC_WAIT) & ~(state_d == ST_STANDBY);
    end
  end

endmodule

// [rtl/hbd_half_bridge.sv]
/*
  One half-bridge with break-before-make sequencing.
  Assumes the requested level changes no faster than the dead time; a
  request is held until the opposite switch has been off long enough.
*/
`timescale 1ns/1ns
module hbd_half_bridge #(
  parameter int unsigned DEAD = hbd_pkg::DEAD_CYC
) (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic rstn,
  // Request: drive enable and level
  input wire logic drive_en,
  input wire logic drive_high,
  // Gate commands
  output hbd_pkg::hbd_gate_t gate
);

  logic [7:0] dead_q;
  logic [7:0] dead_d;
  hbd_pkg::hbd_gate_t gate_q;
  hbd_pkg::hbd_gate_t gate_d;
  hbd_pkg::hbd_gate_t want;

  // Switching off is immediate; switching on waits out the dead time
  wire want_change = (want != gate_q);
  wire any_on = gate_q.high_on | gate_q.low_on;
  wire dead_done = (dead_q == 8'h00);

  assign want.high_on = drive_en & drive_high;
  assign want.low_on = drive_en & ~drive_high;

  always_comb begin
    gate_d = gate_q;
    dead_d = dead_q;
    if (want_change && any_on) begin
      gate_d = '0;
      dead_d = 8'(DEAD);
    end else if (want_change && dead_done) begin
      gate_d = want;
    end else if (!dead_done) begin
      dead_d = dead_q - 8'h01;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!rstn) begin
      gate_q <= '0;
      dead_q <= 8'h00;
    end else begin
      gate_q <= gate_d;
      dead_q <= dead_d;
    end
  end

  assign gate = gate_q;

endmodule

// [rtl/hbd_pkg.sv]
/*
  Package for the H-bridge drive control block: timing constants, bridge
  states and the packed carriers for comparator inputs and gate commands.
  Assumes a 125 MHz system clock.
*/
package hbd_pkg;

  // ==========================================================================
  // Clock
  // ==========================================================================
  localparam int unsigned CLK_MHZ = 125;

  // ==========================================================================
  // Times in their own unit, and cycle counts derived from them
  // ==========================================================================
  localparam int unsigned DEAD_TIME_NS = 200;
  localparam int unsigned DEAD_CYC = (DEAD_TIME_NS * CLK_MHZ + 999) / 1000;
  localparam int unsigned WAKE_HOLD_US = 5;
  localparam int unsigned WAKE_HOLD_CYC = WAKE_HOLD_US * CLK_MHZ;
  localparam int unsigned WAKE_DELAY_US = 60;
  localparam int unsigned WAKE_DELAY_CYC = WAKE_DELAY_US * CLK_MHZ;
  localparam int unsigned OFF_TIME_US = 25;
  localparam int unsigned OFF_TIME_CYC = OFF_TIME_US * CLK_MHZ;
  localparam int unsigned OC_DEG_NS = 1500;
  localparam int unsigned OC_DEG_CYC = (OC_DEG_NS * CLK_MHZ + 999) / 1000;
  localparam int unsigned UV_DEG_US = 10;
  localparam int unsigned UV_DEG_CYC = UV_DEG_US * CLK_MHZ;
  localparam int unsigned IDLE_ENTRY_US = 1000;
  localparam int unsigned IDLE_ENTRY_CYC = IDLE_ENTRY_US * CLK_MHZ;
  localparam int unsigned RETRY_US = 3000;
  localparam int unsigned RETRY_CYC = RETRY_US * CLK_MHZ;

  localparam int unsigned CNT_W = 20;
  localparam int unsigned SYNC_STAGES = 3;

  // ==========================================================================
  // Bridge states and carriers
  // ==========================================================================
  typedef enum logic [1:0] {
    HBD_COAST,
    HBD_REVERSE,
    HBD_FORWARD,
    HBD_BRAKE
  } hbd_drive_t;

  typedef struct packed {
    logic regulation_limit;
    logic overcurrent;
    logic thermal_fault;
    logic supply_low;
  } hbd_sense_t;

  typedef struct packed {
    logic high_on;
    logic low_on;
  } hbd_gate_t;

endpackage

// [rtl/hbd_sync.sv]
/*
  Three-stage synchroniser with agreement filter for asynchronous inputs.
  Assumes a single system clock; the output changes only once the second
  and third stages agree.
*/
`timescale 1ns/1ns
module hbd_sync #(
  parameter int unsigned WIDTH = 1
) (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic rstn,
  // Data
  input wire logic [WIDTH-1:0] async_in,
  output logic [WIDTH-1:0] sync_out
);

  logic [WIDTH-1:0] s1_q;
  logic [WIDTH-1:0] s2_q;
  logic [WIDTH-1:0] s3_q;
  logic [WIDTH-1:0] out_q;
  wire [WIDTH-1:0] agree = ~(s2_q ^ s3_q);
  wire [WIDTH-1:0] out_d = (agree & s3_q) | (~agree & out_q);

  always_ff @(posedge clk_sys) begin
    if (!rstn) begin
      s1_q <= '0;
      s2_q <= '0;
      s3_q <= '0;
      out_q <= '0;
    end else begin
      s1_q <= async_in;
      s2_q <= s1_q;
      s3_q <= s2_q;
      out_q <= out_d;
    end
  end

  assign sync_out = out_q;

endmodule

// [verif/hbd_drive_ctrl_chk.sv]
/*
  Checker for hbd_drive_ctrl: switch safety, fault blanking and timing.
  Assumes it is bound into every instance and sees only its ports.
*/
`timescale 1ns/1ns
module hbd_chk #(
  parameter int unsigned IDLE_CYC = 200,
  parameter int unsigned UV_CYC = 20,
  parameter int unsigned OC_CYC = 8
) (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic rstn,
  // Inputs of the block
  input wire logic bridge_input_a,
  input wire logic bridge_input_b,
  input wire hbd_pkg::hbd_sense_t sense,
  // Outputs of the block
  input wire hbd_pkg::hbd_gate_t gate_a,
  input wire hbd_pkg::hbd_gate_t gate_b,
  input wire logic standby,
  input wire logic overcurrent_fault,
  input wire logic thermal_fault,
  input wire logic supply_low_fault,
  input wire logic internal_supply_on
);
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rstn);
  // ==========================================================
  // Run lengths of the raw inputs
  // ==========================================================
  // Raw pins lead the synchroniser, so a run here is never shorter
  int unsigned idle_q, oc_q, uv_q;
  wire idle_w = !bridge_input_a && !bridge_input_b;
  wire off_w = {gate_a, gate_b} == 4'h0;
  wire fault_w = overcurrent_fault || thermal_fault || supply_low_fault;
  wire hot_w = overcurrent_fault || thermal_fault;
  always_ff @(posedge clk_sys) begin
    idle_q <= (!rstn || !idle_w) ? 0 : idle_q + 1;
    oc_q <= (!rstn || !sense.overcurrent) ? 0 : oc_q + 1;
    uv_q <= (!rstn || !sense.supply_low) ? 0 : uv_q + 1;
  end
  // ==========================================================
  // Properties
  // ==========================================================
  property p_no_shoot;
    gate_a != 2'h3 && gate_b != 2'h3;
  endproperty
  a_no_shoot: assert property (p_no_shoot) else $error("Half bridge shorted");
  property p_dead_a;
    $fell(gate_a.high_on) |-> !gate_a.low_on [*8];
  endproperty
  a_dead_a: assert property (p_dead_a) else $error("Dead time short on A");
  property p_dead_b;
    $fell(gate_b.low_on) |-> !gate_b.high_on [*8];
  endproperty
  a_dead_b: assert property (p_dead_b) else $error("Dead time short on B");
  property p_coast;
    idle_w [*8] |-> off_w;
  endproperty
  a_coast: assert property (p_coast) else $error("Bridge driven while idle");
  property p_standby_off;
    standby |-> off_w;
  endproperty
  a_standby_off: assert property (p_standby_off) else $error("Driven in standby");
  property p_fault_off;
    fault_w && $past(fault_w) |-> off_w;
  endproperty
  a_fault_off: assert property (p_fault_off) else $error("Driven in fault");
  property p_supply_off;
    hot_w && $past(hot_w) |-> !internal_supply_on;
  endproperty
  a_supply_off: assert property (p_supply_off) else $error("Supply on in fault");
  property p_oc_deg;
    $rose(overcurrent_fault) |-> oc_q >= OC_CYC;
  endproperty
  a_oc_deg: assert property (p_oc_deg) else $error("Overcurrent flagged early");
  property p_uv_deg;
    $rose(supply_low_fault) |-> uv_q >= UV_CYC;
  endproperty
  a_uv_deg: assert property (p_uv_deg) else $error("Undervoltage flagged early");
  property p_idle;
    $rose(standby) |-> idle_q >= IDLE_CYC;
  endproperty
  a_idle: assert property (p_idle) else $error("Standby entered early");
endmodule

bind hbd_drive_ctrl hbd_chk #(.IDLE_CYC(IDLE_CYC), .UV_CYC(UV_CYC), .OC_CYC(OC_CYC)) hbd_chk_inst (
  .clk_sys(clk_sys), .rstn(rstn), .bridge_input_a(bridge_input_a),
  .bridge_input_b(bridge_input_b), .sense(sense), .gate_a(gate_a), .gate_b(gate_b),
  .standby(standby), .overcurrent_fault(overcurrent_fault), .thermal_fault(thermal_fault),
  .supply_low_fault(supply_low_fault), .internal_supply_on(internal_supply_on)
);

// [verif/hbd_host.sv]
/*
  Host model: drives the two bridge inputs, static or pulse-width modulated.
  Assumes the bench sets drive code and pulse enable just after an edge.
*/
`timescale 1ns/1ns
module hbd_host #(
  parameter int unsigned HALF = 625
) (
  // Clock
  input wire logic clk_sys,
  // Command
  input wire logic [1:0] drive_code,
  input wire logic pwm_on,
  // Bridge inputs
  output logic bridge_input_a,
  output logic bridge_input_b
);
  // Half period of 625 cycles keeps the pulse rate at 100 kHz
  int unsigned cnt_q = 0;
  logic brake_q = 1'b0;
  always @(posedge clk_sys) begin
    cnt_q <= (cnt_q >= HALF - 1) ? 0 : cnt_q + 1;
    brake_q <= (cnt_q >= HALF - 1) ? !brake_q : brake_q;
  end
  // Pulsing alternates drive with brake, never with coast
  assign {bridge_input_a, bridge_input_b} = (pwm_on && brake_q) ? 2'h3 : drive_code;
endmodule

// [verif/test_hbridge_drive_control.sv]
/*
  Testbench for hbd_drive_ctrl against a table model of the bridge states.
  Assumes the checker is bound in and the host model drives the inputs.
*/
`timescale 1ns/1ns
module test_hbridge_drive_control;
  localparam int IDLE = 200;
  localparam int RETRY = 300;
  localparam int WAKE = 50;
  localparam int HOLD = 10;
  localparam int OFF = 200;
  logic clk_sys = 1'b0;
  logic rstn = 1'b0;
  logic [1:0] code = 2'h0;
  logic pwm_on = 1'b0;
  logic mixed = 1'b0;
  hbd_pkg::hbd_sense_t sense = 4'h0;
  hbd_pkg::hbd_gate_t gate_a, gate_b;
  logic bridge_input_a, bridge_input_b, standby, oc_f, th_f, uv_f, sup_on;
  int fail_count = 0;
  int checked = 0;
  int seed = 32'hCDE10EA7;
  int n, k, m;
  // Gates {a, b} per state: coast, reverse, forward, brake
  int tbl [4] = '{0, 6, 9, 5};
  always #4 clk_sys = !clk_sys;
  hbd_host hbd_host_inst (.clk_sys(clk_sys), .drive_code(code), .pwm_on(pwm_on),
    .bridge_input_a(bridge_input_a), .bridge_input_b(bridge_input_b));
  hbd_drive_ctrl #(.IDLE_CYC(IDLE), .RETRY_CYC(RETRY), .WAKE_CYC(WAKE), .HOLD_CYC(HOLD),
    .OFF_CYC(OFF), .UV_CYC(20), .OC_CYC(8)) hbd_drive_ctrl_inst (.clk_sys(clk_sys),
    .rstn(rstn), .bridge_input_a(bridge_input_a), .bridge_input_b(bridge_input_b),
    .mixed_decay_sel(mixed), .sense(sense), .gate_a(gate_a), .gate_b(gate_b),
    .standby(standby), .overcurrent_fault(oc_f), .thermal_fault(th_f),
    .supply_low_fault(uv_f), .internal_supply_on(sup_on));
  // ==========================================================
  // Tasks
  // ==========================================================
  task automatic end_sim;
    $display("Checked %0d, errors %0d", checked, fail_count);
    if (fail_count == 0 && checked > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask
  task automatic cyc(input int c);
    repeat (c) @(posedge clk_sys);
    #1;
  endtask
  task automatic chk_gate(input string nm, input int st);
    checked++;
    if ({gate_a, gate_b} !== 4'(tbl[st])) begin
      fail_count++;
      $display("Error %s expected %h seen %h", nm, 4'(tbl[st]), {gate_a, gate_b});
    end
  endtask
  task automatic chk_bit(input string nm, input logic exp, input logic seen);
    checked++;
    if (seen !== exp) begin
      fail_count++;
      $display("Error %s expected %b seen %b", nm, exp, seen);
    end
  endtask
  task automatic chk_min(input string nm, input int lo, input int hi, input int seen);
    checked++;
    if (seen < lo || seen > hi) begin
      fail_count++;
      $display("Error %s expected %0d..%0d seen %0d", nm, lo, hi, seen);
    end
  endtask
  // Bounded wait on gates active, overcurrent flag or standby
  task automatic wait_on(input int w, input logic lvl, output int c);
    logic s;
    for (c = 0; c < 1000; c++) begin
      s = (w == 0) ? |{gate_a, gate_b} : (w == 1) ? oc_f : standby;
      if (s === lvl) return;
      cyc(1);
    end
    fail_count++;
    $display("Error wait %0d expected %b seen timeout", w, lvl);
    end_sim;
  endtask
  // ==========================================================
  // Scenarios
  // ==========================================================
  initial begin
    cyc(5);
    rstn = 1'b1;
    chk_bit("standby_rst", 1'b1, standby);
    chk_bit("supply_rst", 1'b0, sup_on);
    code = 2'h2;
    cyc(HOLD + WAKE - 5);
    chk_gate("wake_hold", 0);
    wait_on(0, 1'b1, n);
    chk_min("wake_cyc", 5, 40, n);
    k = $random(seed) & 3;
    for (int i = 0; i < 4; i++) begin
      code = 2'(i ^ k);
      cyc(60 + ($random(seed) & 15));
      chk_gate("decode", i ^ k);
    end
    code = 2'h2;
    cyc(60);
    code = 2'h3;
    m = 0;
    repeat (100) begin
      cyc(1);
      m += (gate_a === 2'h0);
    end
    chk_min("dead_a", hbd_pkg::DEAD_CYC, hbd_pkg::DEAD_CYC + 2, m);
    code = 2'h2;
    pwm_on = 1'b1;
    m = 0;
    repeat (26) begin
      cyc(100);
      m += gate_a.high_on;
      chk_bit("pwm_b_low", 1'b1, gate_b === 2'h1);
    end
    chk_min("pwm_a_high", 9, 16, m);
    pwm_on = 1'b0;
    for (int md = 0; md < 2; md++) begin
      mixed = md[0];
      cyc(60);
      sense = 4'h8;
      cyc(6);
      sense = 4'h0;
      cyc(54);
      chk_gate("decay_first", md ? 1 : 3);
      cyc(100);
      chk_gate("decay_second", 3);
      cyc(140);
      chk_gate("decay_end", 2);
    end
    for (int f = 0; f < 2; f++) begin
      sense = f ? 4'h1 : 4'h2;
      cyc(10);
      chk_bit("early_flag", f == 0, th_f | uv_f);
      cyc(30);
      chk_bit("fault_flag", 1'b1, f ? uv_f : th_f);
      chk_gate("fault_off", 0);
      if (f == 0) chk_bit("hot_supply", 1'b0, sup_on);
      sense = 4'h0;
      cyc(60);
      chk_gate("fault_recover", 2);
    end
    sense = 4'h4;
    cyc(4);
    sense = 4'h0;
    cyc(20);
    chk_bit("oc_glitch", 1'b0, oc_f);
    sense = 4'h4;
    wait_on(1, 1'b1, n);
    chk_min("oc_deglitch", 8, 16, n);
    cyc(2);
    chk_gate("oc_off", 0);
    chk_bit("oc_supply", 1'b0, sup_on);
    cyc(RETRY + 50);
    chk_bit("oc_held", 1'b1, oc_f);
    sense = 4'h0;
    wait_on(1, 1'b0, n);
    chk_min("oc_retry", RETRY, RETRY + 8, n);
    cyc(60);
    chk_gate("oc_resume", 2);
    chk_bit("oc_supply_back", 1'b1, sup_on);
    code = 2'h0;
    wait_on(2, 1'b1, n);
    chk_min("idle_entry", IDLE, IDLE * 3 / 2, n);
    code = 2'h2;
    cyc(200);
    rstn = 1'b0;
    cyc(5);
    chk_bit("standby_rerst", 1'b1, standby);
    chk_gate("rerst_off", 0);
    rstn = 1'b1;
    cyc(20);
    end_sim;
  end
endmodule
